/* File: rtl/icr_pkg.sv */
`default_nettype none
package icr_pkg;
    // register addresses carried in bits 13:9 of the command
    localparam logic [4:0] REG_REGULATOR_ADDR = 5'h05;
    localparam logic [4:0] REG_WATCHDOG_ADDR  = 5'h06;
    // command operation field, bits 15:14
    localparam logic [1:0] CMD_OP_READ        = 2'h0;
    localparam logic [1:0] CMD_OP_WRITE       = 2'h1;
    // power-on defaults
    localparam logic [7:0] REGULATOR_RESET    = 8'h80;
    localparam logic [7:0] WATCHDOG_RESET     = 8'h42;
    // supply undervoltage action codes
    localparam logic [1:0] UV_RST_HIGH_A      = 2'h0;
    localparam logic [1:0] UV_IRQ_HIGH_RST_LOW = 2'h1;
    localparam logic [1:0] UV_RST_LOW         = 2'h2;
    // timing: clock rate and the printed times
    localparam int unsigned SYS_CLK_MHZ       = 25;
    localparam int unsigned RST_LEN_00_MS     = 1;
    localparam int unsigned RST_LEN_01_MS     = 5;
    localparam int unsigned RST_LEN_10_MS     = 10;
    localparam int unsigned RST_LEN_11_MS     = 20;
    localparam int unsigned CYCLIC_00_US      = 200;
    localparam int unsigned CYCLIC_01_US      = 400;
    localparam int unsigned CYCLIC_10_US      = 800;
    localparam int unsigned CYCLIC_11_US      = 1600;
    localparam int unsigned TIMER_W           = 20;
    // one 16-bit command frame, msb first
    typedef struct packed {
        logic [1:0] op;
        logic [4:0] addr;
        logic       parity;
        logic [7:0] data;
    } icr_command_type;
    // regulator set-up register layout
    typedef struct packed {
        logic       io1_sync;
        logic [1:0] supply_undervoltage_select;
        logic [1:0] reset_pulse_length;
        logic       aux_voltage_select;
        logic [1:0] cyclic_on_time;
    } icr_regulator_type;
    // watchdog set-up register layout
    typedef struct packed {
        logic       irq_read_deadline_enable;
        logic       supply_overcurrent_monitor;
        logic       overcurrent_timer_select;
        logic       watchdog_failsafe;
        logic [1:0] watchdog_host_mode;
        logic       watchdog_window_select;
        logic       crank;
    } icr_watchdog_type;
endpackage
`default_nettype wire

/* File: rtl/icr_spi_rx.sv */
`default_nettype none
// spi slave, mode 0, msb first, 16-bit frames
module icr_spi_rx (
    input  wire logic        i_sys_clk,     // system clock
    input  wire logic        i_rst_n,       // synchronous reset
    input  wire logic        i_sclk,        // spi clock pin
    input  wire logic        i_cs_n,        // spi select pin, active low
    input  wire logic        i_mosi,        // spi data in pin
    input  wire logic [15:0] i_response,    // word shifted out in the next frame
    output logic             o_miso,        // spi data out
    output logic             o_frame_valid, // one-cycle pulse, full frame received
    output logic [15:0]      o_frame        // received word
);
    logic [2:0]  sclk_sync_q;
    logic [2:0]  cs_sync_q;
    logic [1:0]  mosi_sync_q;
    logic [15:0] shift_in_q;
    logic [15:0] shift_out_q;
    logic [4:0]  count_q;
    logic        valid_q;
    wire         sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    wire         sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2];
    wire         cs_fall   = ~cs_sync_q[1] & cs_sync_q[2];
    wire         cs_rise   = cs_sync_q[1] & ~cs_sync_q[2];
    wire         selected  = ~cs_sync_q[1];

    // pin synchronisers, extra stage for edge detection
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sclk_sync_q <= 3'h0;
            cs_sync_q   <= 3'h7;
            mosi_sync_q <= 2'h0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], i_sclk};
            cs_sync_q   <= {cs_sync_q[1:0], i_cs_n};
            mosi_sync_q <= {mosi_sync_q[0], i_mosi};
        end
    end

    // shift in on rising sclk, out on falling sclk
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            shift_in_q  <= 16'h0000;
            shift_out_q <= 16'h0000;
            count_q     <= 5'h00;
            valid_q     <= 1'b0;
        end else begin
            valid_q <= cs_rise && count_q == 5'h10;
            if (cs_fall) begin
                shift_out_q <= i_response;
                count_q     <= 5'h00;
            end else if (selected && sclk_rise) begin
                shift_in_q <= {shift_in_q[14:0], mosi_sync_q[1]};
                if (count_q != 5'h1f) begin
                    count_q <= count_q + 5'h01;
                end
            end else if (selected && sclk_fall) begin
                shift_out_q <= {shift_out_q[14:0], 1'b0};
            end
        end
    end

    assign o_miso        = shift_out_q[15];
    assign o_frame_valid = valid_q;
    assign o_frame       = shift_in_q;
endmodule
`default_nettype wire

/* File: rtl/icr_config_regs.sv */
// Operation
// - set-up registers accept writes only during the initialization phase
// - address 0_0101 in first byte selects regulator set-up, data second byte
// - bit 7: 0 senses I/O-1 anytime, 1 only during I/O-0 cyclic activation
// - bits 6:5: 00/11 reset 0.9, 10 reset 0.7, 01 irq 0.9 plus reset 0.7
// - bits 4:3 set reset low time after supply recovers: 1, 5, 10, 20 ms
// - bit 2 selects auxiliary regulator 3.3 V when clear, 5.0 V when set
// - bits 1:0 set I/O-0 cyclic on-time 200, 400, 800, 1600 us
// - address 0_0110 selects watchdog set-up register with its seven fields
`default_nettype none
module icr_config_regs #(
    parameter logic [19:0] P_RST_00_CYC = 20'(icr_pkg::RST_LEN_00_MS * 1000 * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_RST_01_CYC = 20'(icr_pkg::RST_LEN_01_MS * 1000 * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_RST_10_CYC = 20'(icr_pkg::RST_LEN_10_MS * 1000 * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_RST_11_CYC = 20'(icr_pkg::RST_LEN_11_MS * 1000 * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_CYC_00_CYC = 20'(icr_pkg::CYCLIC_00_US * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_CYC_01_CYC = 20'(icr_pkg::CYCLIC_01_US * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_CYC_10_CYC = 20'(icr_pkg::CYCLIC_10_US * icr_pkg::SYS_CLK_MHZ),
    parameter logic [19:0] P_CYC_11_CYC = 20'(icr_pkg::CYCLIC_11_US * icr_pkg::SYS_CLK_MHZ)
) (
    input  wire logic                     i_sys_clk,        // 25 MHz system clock
    input  wire logic                     i_rst_n,          // power-on reset, sync, low
    input  wire logic                     i_sclk,           // spi clock pin
    input  wire logic                     i_cs_n,           // spi select pin, low
    input  wire logic                     i_mosi,           // spi data in pin
    output logic                          o_miso,           // spi data out pin
    input  wire logic                     i_init_phase,     // device is in init phase
    input  wire logic                     i_parity_enable,  // odd parity check on
    input  wire logic                     i_vdd_above_high, // supply above 0.9 comparator
    input  wire logic                     i_vdd_above_low,  // supply above 0.7 comparator
    output icr_pkg::icr_regulator_type    o_regulator,      // regulator set-up contents
    output icr_pkg::icr_watchdog_type     o_watchdog,       // watchdog set-up contents
    output logic                          o_io1_sync_only,  // sense I/O-1 during I/O-0 only
    output logic                          o_aux_5v,         // aux regulator at 5.0 V
    output logic [icr_pkg::TIMER_W-1:0]   o_cyclic_on_cycles, // I/O-0 on-time in cycles
    output logic                          o_reset_n,        // reset output, low active
    output logic                          o_uv_irq,         // undervoltage warning level
    output logic                          o_write_rejected  // pulse, write dropped
);
    typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} icr_reset_state_type;

    icr_pkg::icr_regulator_type regulator_q;
    icr_pkg::icr_watchdog_type  watchdog_q;
    icr_pkg::icr_command_type   cmd;
    icr_reset_state_type        state_q;
    icr_reset_state_type        state_d;
    logic [19:0]                timer_q;
    logic [19:0]                timer_d;
    logic [19:0]                cyclic_q;
    logic [15:0]                response_q;
    logic [15:0]                frame;
    logic                       frame_valid;
    logic                       reject_q;
    logic                       reset_out_q;
    logic                       uv_irq_q;
    logic [1:0]                 high_sync_q;
    logic [1:0]                 low_sync_q;

    // serial command port
    icr_spi_rx icr_spi_rx_i (
        .i_sys_clk     (i_sys_clk),
        .i_rst_n       (i_rst_n),
        .i_sclk        (i_sclk),
        .i_cs_n        (i_cs_n),
        .i_mosi        (i_mosi),
        .i_response    (response_q),
        .o_miso        (o_miso),
        .o_frame_valid (frame_valid),
        .o_frame       (frame)
    );

    // command decode; parity ignored when disabled, host keeps it zero
    assign cmd = frame;
    wire parity_ok  = !i_parity_enable || (^frame);
    wire is_write   = frame_valid && cmd.op == icr_pkg::CMD_OP_WRITE && parity_ok;
    wire is_read    = frame_valid && cmd.op == icr_pkg::CMD_OP_READ && parity_ok;
    wire hit_reg    = cmd.addr == icr_pkg::REG_REGULATOR_ADDR;
    wire hit_wd     = cmd.addr == icr_pkg::REG_WATCHDOG_ADDR;
    wire wr_reg     = is_write && hit_reg && i_init_phase;
    wire wr_wd      = is_write && hit_wd && i_init_phase;
    wire wr_dropped = is_write && (hit_reg || hit_wd) && !i_init_phase;
    wire [7:0] read_data = hit_reg ? regulator_q : (hit_wd ? watchdog_q : 8'h00);

    // configuration storage, defaults on power-on reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            regulator_q <= icr_pkg::REGULATOR_RESET;
            watchdog_q  <= icr_pkg::WATCHDOG_RESET;
            response_q  <= 16'h0000;
            reject_q    <= 1'b0;
        end else begin
            if (wr_reg) begin
                regulator_q <= cmd.data;
            end
            if (wr_wd) begin
                watchdog_q <= cmd.data;
            end
            if (is_read) begin
                response_q <= {8'h00, read_data};
            end
            reject_q <= wr_dropped;
        end
    end

    // supply comparators come from analog, two flip-flops each
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            high_sync_q <= 2'h0;
            low_sync_q  <= 2'h0;
        end else begin
            high_sync_q <= {high_sync_q[0], i_vdd_above_high};
            low_sync_q  <= {low_sync_q[0], i_vdd_above_low};
        end
    end

    // threshold selection by undervoltage action
    wire [1:0] uv_sel     = regulator_q.supply_undervoltage_select;
    wire       rst_at_low = uv_sel == icr_pkg::UV_IRQ_HIGH_RST_LOW ||
                            uv_sel == icr_pkg::UV_RST_LOW;
    wire       supply_ok  = rst_at_low ? low_sync_q[1] : high_sync_q[1];
    wire       uv_warn    = uv_sel == icr_pkg::UV_IRQ_HIGH_RST_LOW &&
                            !high_sync_q[1];

    // reset stretch length selection
    wire [19:0] stretch_cyc =
        regulator_q.reset_pulse_length == 2'h0 ? P_RST_00_CYC :
        regulator_q.reset_pulse_length == 2'h1 ? P_RST_01_CYC :
        regulator_q.reset_pulse_length == 2'h2 ? P_RST_10_CYC : P_RST_11_CYC;

    // cyclic sense on-time selection
    wire [19:0] cyclic_cyc =
        regulator_q.cyclic_on_time == 2'h0 ? P_CYC_00_CYC :
        regulator_q.cyclic_on_time == 2'h1 ? P_CYC_01_CYC :
        regulator_q.cyclic_on_time == 2'h2 ? P_CYC_10_CYC : P_CYC_11_CYC;

    // reset output sequencer
    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        unique case (state_q)
            ST_HOLD: begin
                if (supply_ok) begin
                    state_d = ST_STRETCH;
                    timer_d = stretch_cyc - 20'h0_0001;
                end
            end
            ST_STRETCH: begin
                if (!supply_ok) begin
                    state_d = ST_HOLD;
                end else if (timer_q == 20'h0_0000) begin
                    state_d = ST_RUN;
                end else begin
                    timer_d = timer_q - 20'h0_0001;
                end
            end
            ST_RUN: begin
                if (!supply_ok) begin
                    state_d = ST_HOLD;
                end
            end
        endcase
    end

    // sequencer and output registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_q     <= ST_HOLD;
            timer_q     <= 20'h0_0000;
            reset_out_q <= 1'b0;
            uv_irq_q    <= 1'b0;
            cyclic_q    <= 20'h0_0000;
        end else begin
            state_q     <= state_d;
            timer_q     <= timer_d;
            reset_out_q <= state_d == ST_RUN;
            uv_irq_q    <= uv_warn;
            cyclic_q    <= cyclic_cyc;
        end
    end

    assign o_regulator        = regulator_q;
    assign o_watchdog         = watchdog_q;
    assign o_io1_sync_only    = regulator_q.io1_sync;
    assign o_aux_5v           = regulator_q.aux_voltage_select;
    assign o_cyclic_on_cycles = cyclic_q;
    assign o_reset_n          = reset_out_q;
    assign o_uv_irq           = uv_irq_q;
    assign o_write_rejected   = reject_q;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_supply_recovers;
        state_q == ST_HOLD && supply_ok;
    endsequence
    sequence s_stretch_lands;
        state_q == ST_STRETCH && supply_ok && timer_q == 20'h0_0000;
    endsequence

    a_init_write_takes: assert property (wr_reg |=> regulator_q == $past(cmd.data))
        else $error("regulator write in init phase not stored");
    a_other_addr_keep: assert property (frame_valid && !hit_reg && !wr_dropped
        |=> $stable(regulator_q))
        else $error("regulator changed by another address");
    a_io1_sync_bit: assert property (wr_reg |=> o_io1_sync_only == $past(frame[7]))
        else $error("io1 sync output does not follow bit 7");
    a_uv_irq_level: assert property (uv_sel == icr_pkg::UV_IRQ_HIGH_RST_LOW
        && !high_sync_q[1] && $stable(uv_sel) |=> o_uv_irq)
        else $error("undervoltage warning not raised");
    a_uv_high_reset: assert property (!high_sync_q[1]
        && (uv_sel == icr_pkg::UV_RST_HIGH_A || uv_sel == 2'h3) |=> !o_reset_n)
        else $error("reset not asserted below high threshold");
    a_reset_stretch: assert property (s_supply_recovers ##1 supply_ok[*2]
        |-> !o_reset_n)
        else $error("reset released before stretch");
    a_reset_release: assert property ($rose(o_reset_n)
        |-> $past(state_q == ST_STRETCH && timer_q == 20'h0_0000))
        else $error("reset released without full stretch count");
    a_stretch_exit: assert property (s_stretch_lands
        |=> state_q == ST_RUN && o_reset_n)
        else $error("stretch end did not release reset");
    a_aux_select: assert property (wr_reg |=> o_aux_5v == $past(frame[2]))
        else $error("aux voltage select does not follow bit 2");
    a_cyclic_max: assert property (regulator_q.cyclic_on_time == 2'h3
        && $stable(regulator_q) |=> o_cyclic_on_cycles == P_CYC_11_CYC)
        else $error("cyclic on-time wrong for code 11");
    a_wd_write: assert property (wr_wd |=> watchdog_q == $past(cmd.data))
        else $error("watchdog set-up write not stored");
    a_drop_outside: assert property (wr_dropped
        |=> $stable(regulator_q) && $stable(watchdog_q) && o_write_rejected)
        else $error("write outside init phase not discarded");
    a_por_defaults: assert property ($rose(i_rst_n)
        |-> regulator_q == icr_pkg::REGULATOR_RESET
        && watchdog_q == icr_pkg::WATCHDOG_RESET && !o_reset_n)
        else $error("defaults not loaded on reset");
endmodule
`default_nettype wire

/* File: test/icr_spi_host.sv */
`default_nettype none
// host side model: mode 0, msb first, 16-bit frames, clock stands low between frames
module icr_spi_host (
    input  wire logic i_sys_clk, // system clock, pacing only
    input  wire logic i_miso,    // data from the device
    output logic      o_sclk,    // spi clock
    output logic      o_cs_n,    // select, low during a frame
    output logic      o_mosi     // data to the device
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rx_q; // word shifted in during the last frame
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
        rx_q   = 16'h0000;
    end
    // one whole frame, each clock phase 4 system cycles, select high 8 cycles after
    task automatic xfer(input logic [1:0] op, input logic [4:0] addr, input logic [7:0] data,
                        input logic par_on, input logic bad);
        logic [15:0] w;
        w = {op, addr, 1'b0, data};
        if (par_on) begin
            w[8] = (~^w) ^ bad; // odd count of ones, or broken on purpose
        end
        @(negedge i_sys_clk);
        o_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_mosi = w[i];
            repeat (4) @(negedge i_sys_clk);
            o_sclk = 1'b1;
            rx_q = {rx_q[14:0], i_miso};
            repeat (4) @(negedge i_sys_clk);
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_sys_clk);
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi; // released line does not keep its last value
        repeat (8) @(negedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

/* File: test/tb_icr_config_regs.sv */
`default_nettype none
// self-checking bench for the set-up register bank
module tb_icr_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] RST_CYC [4] = '{20'h0_000A, 20'h0_0014, 20'h0_0028, 20'h0_0050};
    localparam logic [19:0] CYC_CYC [4] = '{20'h0_000C, 20'h0_0018, 20'h0_0030, 20'h0_0060};
    logic                       sys_clk, rst_n, sclk, cs_n, mosi, miso;
    logic                       init_phase, parity_enable, vdd_hi, vdd_lo;
    icr_pkg::icr_regulator_type regulator;
    icr_pkg::icr_watchdog_type  watchdog;
    logic                       io1, aux5v, reset_n, uv_irq, rej;
    logic [19:0]                cyc;
    int                         n_errors, cmp_count, rej_count;
    icr_config_regs #(.P_RST_00_CYC(RST_CYC[0]), .P_RST_01_CYC(RST_CYC[1]),
        .P_RST_10_CYC(RST_CYC[2]), .P_RST_11_CYC(RST_CYC[3]), .P_CYC_00_CYC(CYC_CYC[0]),
        .P_CYC_01_CYC(CYC_CYC[1]), .P_CYC_10_CYC(CYC_CYC[2]), .P_CYC_11_CYC(CYC_CYC[3])
    ) icr_config_regs_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_mosi(mosi), .o_miso(miso), .i_init_phase(init_phase),
        .i_parity_enable(parity_enable), .i_vdd_above_high(vdd_hi), .i_vdd_above_low(vdd_lo),
        .o_regulator(regulator), .o_watchdog(watchdog), .o_io1_sync_only(io1),
        .o_aux_5v(aux5v), .o_cyclic_on_cycles(cyc), .o_reset_n(reset_n), .o_uv_irq(uv_irq),
        .o_write_rejected(rej));
    icr_spi_host icr_spi_host_i (.i_sys_clk(sys_clk), .i_miso(miso), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_mosi(mosi));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // count each cycle the drop pulse is seen, sampled where it is settled
    always @(negedge sys_clk) begin
        if (rej === 1'b1) rej_count++;
    end
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        icr_spi_host_i.xfer(icr_pkg::CMD_OP_WRITE, a, d, 1'b0, 1'b0);
        repeat (8) @(negedge sys_clk);
    endtask
    // read answer comes in the following frame
    task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
        icr_spi_host_i.xfer(icr_pkg::CMD_OP_READ, a, 8'h00, 1'b0, 1'b0);
        icr_spi_host_i.xfer(icr_pkg::CMD_OP_READ, a, 8'h00, 1'b0, 1'b0);
        check(20'(icr_spi_host_i.rx_q), {12'h000, exp});
    endtask
    task automatic wait_reset_high(output int n);
        n = 0;
        while (reset_n !== 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 400) begin
                n_errors++;
                $display("[FAIL] %0t reset output stuck low", $time);
                summarize();
            end
        end
    endtask
    task automatic test_defaults();
        int n;
        wait_reset_high(n);
        check_rng(n, RST_CYC[0], RST_CYC[0] + 8);
        check(20'(regulator), 20'h0_0080);
        check(20'(watchdog), 20'h0_0042);
        check(cyc, CYC_CYC[0]);
        rd_check(icr_pkg::REG_REGULATOR_ADDR, 8'h80);
        rd_check(icr_pkg::REG_WATCHDOG_ADDR, 8'h42);
        rd_check(5'h07, 8'h00);
        $display("test defaults done");
    endtask
    task automatic test_fields();
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1:0], i[1:0], ~i[0], 2'(i)};
            wr(icr_pkg::REG_REGULATOR_ADDR, d);
            check(20'(regulator), 20'(d));
            check(20'(io1), 20'(d[7]));
            check(20'(aux5v), 20'(d[2]));
            check(cyc, CYC_CYC[i]);
            check(20'(watchdog), 20'h0_0042);
        end
        $display("test fields done");
    endtask
    task automatic test_watchdog_parity();
        wr(icr_pkg::REG_WATCHDOG_ADDR, 8'hA5);
        check(20'(watchdog), 20'h0_00A5);
        rd_check(icr_pkg::REG_WATCHDOG_ADDR, 8'hA5);
        parity_enable = 1'b1;
        icr_spi_host_i.xfer(icr_pkg::CMD_OP_WRITE, icr_pkg::REG_WATCHDOG_ADDR, 8'h3C, 1'b1, 1'b1);
        repeat (8) @(negedge sys_clk);
        check(20'(watchdog), 20'h0_00A5);
        icr_spi_host_i.xfer(icr_pkg::CMD_OP_WRITE, icr_pkg::REG_WATCHDOG_ADDR, 8'h3C, 1'b1, 1'b0);
        repeat (8) @(negedge sys_clk);
        check(20'(watchdog), 20'h0_003C);
        parity_enable = 1'b0;
        $display("test watchdog and parity done");
    endtask
    task automatic test_supply();
        int n;
        for (int k = 0; k < 4; k++) begin
            wr(icr_pkg::REG_REGULATOR_ADDR, {1'b0, 2'(k), 2'(k), 3'b000});
            vdd_hi = 1'b0;
            repeat (8) @(negedge sys_clk);
            check(20'(reset_n), 20'((k == 1 || k == 2) ? 1 : 0));
            check(20'(uv_irq), 20'(k == 1));
            vdd_lo = 1'b0;
            repeat (8) @(negedge sys_clk);
            check(20'(reset_n), 20'h0_0000);
            vdd_lo = 1'b1;
            vdd_hi = 1'b1;
            wait_reset_high(n);
            check_rng(n, RST_CYC[k], RST_CYC[k] + 8);
        end
        $display("test supply done");
    endtask
    task automatic test_locked();
        int r0;
        init_phase = 1'b0;
        r0 = rej_count;
        wr(icr_pkg::REG_REGULATOR_ADDR, 8'h55);
        wr(icr_pkg::REG_WATCHDOG_ADDR, 8'hFF);
        check(20'(rej_count - r0), 20'h0_0002);
        check(20'(regulator), 20'h0_0078);
        check(20'(watchdog), 20'h0_003C);
        $display("test locked done");
    endtask
    initial begin
        {n_errors, cmp_count, rej_count} = '0;
        rst_n = 1'b0;
        init_phase = 1'b1;
        parity_enable = 1'b0;
        vdd_hi = 1'b1;
        vdd_lo = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        test_defaults();
        test_fields();
        test_watchdog_parity();
        test_supply();
        test_locked();
        summarize();
    end
    // cut a hang short
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
